// ---- pkg/fscc_params.svh ----
`ifndef FSCC_PARAMS_SVH
`define FSCC_PARAMS_SVH

// Opcodes
`define FSCC_OP_WR_ENABLE   8'h06
`define FSCC_OP_WR_DISABLE  8'h04
`define FSCC_OP_WR_STAT1    8'h01
`define FSCC_OP_WR_STAT2    8'h31
`define FSCC_OP_RD_CFG      8'h3F
`define FSCC_OP_WR_CFG      8'h3E
`define FSCC_OP_QUAD_PROG   8'h32
`define FSCC_OP_QUAD_READ   8'h6B

// Field positions in the data byte
`define FSCC_LOCK_POS       7
`define FSCC_GLOBAL_HI      5
`define FSCC_GLOBAL_LO      2
`define FSCC_RST_ALLOW_POS  4
`define FSCC_LKD_ALLOW_POS  3
`define FSCC_QUAD_POS       7

// Global protect codes
`define FSCC_GLOBAL_PROT    4'hF
`define FSCC_GLOBAL_UNPROT  4'h0

// Reset values
`define FSCC_RST_LOCK       1'b0
`define FSCC_RST_ALLOW      1'b0
`define FSCC_RST_WEL        1'b0
`define FSCC_CFG_RESERVED   7'h00

`endif

// ---- pkg/fscc_pkg.sv ----
package fscc_pkg;

    // Frame phase, Gray along idle -> opcode -> data -> done
    typedef enum logic [1:0]
    {
        FSCC_IDLE = 2'b00,
        FSCC_OPC  = 2'b01,
        FSCC_DATA = 2'b11,
        FSCC_DONE = 2'b10
    } fscc_phase_t;

endpackage

// ---- hw/fscc_sync.sv ----
module fscc_sync
#(
    parameter int                 WIDTH = 1,
    parameter logic [WIDTH-1:0]   INIT  = '0
)
(
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;

    initial
    begin
        if (WIDTH < 1)
            $error("fscc_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            meta_ff  <= INIT;
            sync_out <= INIT;
        end
        else
        begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

// ---- hw/fscc_top.sv ----
`include "fscc_params.svh"

// Overview of operation
// - Program-paused and erase-paused flags show whether a sector is suspended.
// - Busy flag is 1 during an internal program or erase, else 0.
// - Opcode 01h plus one byte: bit 7 lock, bits 5:2 global code.
// - Valid 01h at chip select rise updates lock and clears write latch.
// - Global protect or unprotect chosen from bits 5:2 and prior lock.
// - Incomplete or off-boundary 01h aborts; lock kept, latch cleared.
// - With write-protect asserted lock may only be set; clearing is ignored.
// - Opcode 31h plus one byte: bit 4 reset allow, bit 3 lockdown allow.
// - Valid 31h updates both allows, but lockdown allow is held at 0 while frozen; latch cleared.
// - Incomplete or off-boundary 31h keeps both allows, clears latch.
// - Configuration is readable only while the device is idle.
// - After opcode 3Fh the configuration byte shifts out on serial output.
// - Configuration byte repeats while chip select is low and clock runs.
// - Chip select high ends configuration read and floats serial output.
// - Configuration persists across power cycles and soft reset.
// - Quad enable 1 accepts quad commands and frees protect and hold pins.
// - Quad enable 0 rejects quad opcodes; protect and hold act normally.
// - Configuration bits 6:0 read zero; only bit 7 is writable.
// - Write latch 0 refuses status and configuration writes; quad program 32h is accepted regardless.
// - Lock and allow bits and write latch reset to 0.
module fscc_top
(
    // System
    input  wire logic clk_sys,
    input  wire logic rstn,
    // Serial link pins
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    output logic      so_out,
    output logic      so_oe_n,
    input  wire logic wp_n_in,
    output logic      wp_n_out,
    output logic      wp_n_oe_n,
    input  wire logic hold_n_in,
    output logic      hold_n_out,
    output logic      hold_n_oe_n,
    // Core state
    input  wire logic busy_in,
    input  wire logic prog_paused_in,
    input  wire logic erase_paused_in,
    input  wire logic lockdown_frozen,
    input  wire logic nv_quad_io_enable,
    // Status flags
    output logic      busy_flag,
    output logic      program_paused_flag,
    output logic      erase_paused_flag,
    output logic      write_latch_flag,
    output logic      protection_lock_bit,
    output logic      soft_reset_allow,
    output logic      lockdown_allow,
    // Command pulses and quad write data
    output logic      global_protect,
    output logic      global_unprotect,
    output logic      nv_quad_wr,
    output logic      nv_quad_wdata,
    output logic      quad_cmd_accept,
    output logic      bad_cmd
);
    import fscc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    logic        cs_s;
    logic        sck_s;
    logic        si_s;
    logic        wp_s;
    logic        hold_s;
    logic        cs_d_ff;
    logic        sck_d_ff;

    // Reset to idle pin levels, so no false clock edge appears after reset
    fscc_sync #(.WIDTH(5), .INIT(5'h13)) u_sync
    (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .async_in ({cs_n, sck, si, wp_n_in, hold_n_in}),
        .sync_out ({cs_s, sck_s, si_s, wp_s, hold_s})
    );

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            cs_d_ff  <= 1'b1;
            sck_d_ff <= 1'b0;
        end
        else
        begin
            cs_d_ff  <= cs_s;
            sck_d_ff <= sck_s;
        end
    end

    logic        qe;
    logic        held;
    logic        active;
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_rise;
    logic        wp_active;

    assign qe        = nv_quad_io_enable;
    assign held      = !qe && !hold_s;
    assign wp_active = !qe && !wp_s;
    assign active    = !cs_s && !held;
    assign sck_rise  = active && sck_s && !sck_d_ff;
    assign sck_fall  = active && !sck_s && sck_d_ff;
    assign cs_rise   = cs_s && !cs_d_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Byte framing

    fscc_phase_t phase_ff;
    logic [2:0]  bit_cnt_ff;
    logic [7:0]  shift_ff;
    logic [7:0]  opcode_ff;
    logic [7:0]  data_ff;
    logic [7:0]  nxt_byte;
    logic        byte_done;

    assign nxt_byte  = {shift_ff[6:0], si_s};
    assign byte_done = sck_rise && (bit_cnt_ff == 3'h7);

    always_ff @(posedge clk_sys)
    begin
        if (!rstn || cs_s)
        begin
            phase_ff   <= FSCC_OPC;
            bit_cnt_ff <= 3'h0;
            shift_ff   <= 8'h00;
        end
        else if (sck_rise)
        begin
            shift_ff   <= nxt_byte;
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (byte_done)
            begin
                case (phase_ff)
                    FSCC_OPC:  phase_ff <= FSCC_DATA;
                    FSCC_DATA: phase_ff <= FSCC_DONE;
                    FSCC_DONE: phase_ff <= FSCC_DONE;
                    default:   phase_ff <= FSCC_OPC;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            opcode_ff <= 8'h00;
            data_ff   <= 8'h00;
        end
        else if (byte_done && phase_ff == FSCC_OPC)
            opcode_ff <= nxt_byte;
        else if (byte_done && phase_ff == FSCC_DATA)
            data_ff <= nxt_byte;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Commit at chip select rise

    logic        opc_full;
    logic        data_ok;
    logic        is_wr_cmd;
    logic        commit;
    logic        new_lock;
    logic        lock_refused;
    logic [3:0]  global_code;

    assign opc_full     = (phase_ff == FSCC_DATA) || (phase_ff == FSCC_DONE);
    assign data_ok      = (phase_ff == FSCC_DONE) && (bit_cnt_ff == 3'h0);
    assign is_wr_cmd    = (opcode_ff == `FSCC_OP_WR_STAT1) || (opcode_ff == `FSCC_OP_WR_STAT2)
                       || (opcode_ff == `FSCC_OP_WR_CFG);
    assign commit       = cs_rise && opc_full && write_latch_flag && data_ok;
    assign new_lock     = data_ff[`FSCC_LOCK_POS];
    assign lock_refused = wp_active && !new_lock && protection_lock_bit;
    assign global_code  = data_ff[`FSCC_GLOBAL_HI:`FSCC_GLOBAL_LO];

    // Latch clears on any whole write opcode, even aborted or refused
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            write_latch_flag <= `FSCC_RST_WEL;
        else if (cs_rise && opc_full)
        begin
            if (opcode_ff == `FSCC_OP_WR_ENABLE && bit_cnt_ff == 3'h0)
                write_latch_flag <= 1'b1;
            else if (opcode_ff == `FSCC_OP_WR_DISABLE || is_wr_cmd)
                write_latch_flag <= 1'b0;
        end
    end

    logic        wr1_go;
    assign wr1_go = commit && opcode_ff == `FSCC_OP_WR_STAT1 && !lock_refused;

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            protection_lock_bit <= `FSCC_RST_LOCK;
            global_protect      <= 1'b0;
            global_unprotect    <= 1'b0;
        end
        else
        begin
            global_protect   <= 1'b0;
            global_unprotect <= 1'b0;
            if (wr1_go)
            begin
                protection_lock_bit <= new_lock;
                // Prior lock state gates the global operation
                if (!protection_lock_bit)
                begin
                    global_protect   <= (global_code == `FSCC_GLOBAL_PROT);
                    global_unprotect <= (global_code == `FSCC_GLOBAL_UNPROT);
                end
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            soft_reset_allow <= `FSCC_RST_ALLOW;
            lockdown_allow   <= `FSCC_RST_ALLOW;
        end
        else
        begin
            if (commit && opcode_ff == `FSCC_OP_WR_STAT2)
                soft_reset_allow <= data_ff[`FSCC_RST_ALLOW_POS];
            if (lockdown_frozen)
                lockdown_allow <= 1'b0;
            else if (commit && opcode_ff == `FSCC_OP_WR_STAT2)
                lockdown_allow <= data_ff[`FSCC_LKD_ALLOW_POS];
        end
    end

    // Quad bit lives in external non-volatile storage; only bit 7 is written
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            nv_quad_wr    <= 1'b0;
            nv_quad_wdata <= 1'b0;
        end
        else
        begin
            nv_quad_wr <= commit && opcode_ff == `FSCC_OP_WR_CFG;
            if (commit && opcode_ff == `FSCC_OP_WR_CFG)
                nv_quad_wdata <= data_ff[`FSCC_QUAD_POS];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags and opcode classification

    logic        is_quad_op;
    assign is_quad_op = (nxt_byte == `FSCC_OP_QUAD_PROG) || (nxt_byte == `FSCC_OP_QUAD_READ);

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            busy_flag           <= 1'b0;
            program_paused_flag <= 1'b0;
            erase_paused_flag   <= 1'b0;
            quad_cmd_accept     <= 1'b0;
            bad_cmd             <= 1'b0;
        end
        else
        begin
            busy_flag           <= busy_in;
            program_paused_flag <= prog_paused_in;
            erase_paused_flag   <= erase_paused_in;
            quad_cmd_accept     <= byte_done && phase_ff == FSCC_OPC && is_quad_op && qe;
            bad_cmd             <= byte_done && phase_ff == FSCC_OPC && is_quad_op && !qe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration read path

    logic        rd_cfg_ff;
    logic [7:0]  cfg_byte;
    assign cfg_byte = {qe, `FSCC_CFG_RESERVED};

    always_ff @(posedge clk_sys)
    begin
        if (!rstn || cs_s)
            rd_cfg_ff <= 1'b0;
        else if (byte_done && phase_ff == FSCC_OPC)
            rd_cfg_ff <= (nxt_byte == `FSCC_OP_RD_CFG) && !busy_flag;
    end

    // Bit counter wraps every eight edges, so the byte repeats by itself
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            so_out  <= 1'b0;
            so_oe_n <= 1'b1;
        end
        else if (cs_s || held)
            so_oe_n <= 1'b1;
        else if (sck_fall && rd_cfg_ff)
        begin
            so_out  <= cfg_byte[3'h7 - bit_cnt_ff];
            so_oe_n <= 1'b0;
        end
    end

    // Quad data lanes are served elsewhere; these pins stay released here
    always_ff @(posedge clk_sys)
    begin
        wp_n_out    <= 1'b0;
        wp_n_oe_n   <= 1'b1;
        hold_n_out  <= 1'b0;
        hold_n_oe_n <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    AST_BUSY_FOLLOWS: assert property (busy_in |=> busy_flag ##0 $past(busy_in))
        else $error("busy flag did not follow core");
    AST_PAUSE_FLAGS: assert property (##1 program_paused_flag == $past(prog_paused_in)
        && erase_paused_flag == $past(erase_paused_in))
        else $error("pause flags wrong");
    AST_WR1_CLEARS_WEL: assert property (cs_rise && opc_full && opcode_ff == `FSCC_OP_WR_STAT1
        |=> !write_latch_flag)
        else $error("write latch not cleared after status write 1");
    AST_WR1_ABORT: assert property (cs_rise && bit_cnt_ff != 3'h0
        |=> $stable(protection_lock_bit) && !global_protect && !global_unprotect)
        else $error("aborted status write changed lock");
    AST_WP_REFUSE: assert property (cs_rise && wp_active && protection_lock_bit
        |=> protection_lock_bit)
        else $error("lock cleared under write protect");
    AST_GLOBAL_PRIOR: assert property (global_protect || global_unprotect
        |-> !$past(protection_lock_bit) && $past(write_latch_flag))
        else $error("global operation with prior lock set");
    AST_WR2_ABORT: assert property (cs_rise && !data_ok
        |=> $stable(soft_reset_allow) && $stable(lockdown_allow) || lockdown_frozen)
        else $error("aborted status write 2 changed allows");
    AST_NO_WEL: assert property (cs_rise && !write_latch_flag
        |=> $stable(protection_lock_bit) && $stable(soft_reset_allow) && !nv_quad_wr)
        else $error("write taken with latch clear");
    AST_FROZEN: assert property (lockdown_frozen |=> !lockdown_allow)
        else $error("lockdown allow set while frozen");
    AST_SO_FLOAT: assert property (cs_s |=> so_oe_n [*2])
        else $error("serial output driven while deselected");
    AST_CFG_RESERVED: assert property (sck_fall && rd_cfg_ff && bit_cnt_ff != 3'h0
        |=> !so_out && !so_oe_n)
        else $error("reserved configuration bit not zero");
    AST_QUAD_BAD: assert property (bad_cmd |-> !qe && !quad_cmd_accept)
        else $error("quad opcode accepted with quad disabled");

    COV_WR1: cover property (global_protect);
    COV_WR2: cover property (commit && opcode_ff == `FSCC_OP_WR_STAT2);
    COV_CFG_REPEAT: cover property (rd_cfg_ff && sck_fall && bit_cnt_ff == 3'h0 ##[1:100]
        (rd_cfg_ff && sck_fall && bit_cnt_ff == 3'h0));
    COV_QUAD: cover property (quad_cmd_accept);
endmodule

// ---- dv/fscc_host_model.sv ----
module fscc_host_model
(
    // System
    input  wire logic clk_sys,
    // Serial link
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    input  wire logic so_out,
    input  wire logic so_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;

    logic so_line;
    logic oe_seen;

    // A floating output shows the opposite level, so a stale bit never passes
    assign so_line = (so_oe_n === 1'b0) ? so_out : ~so_out;

    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        oe_seen = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Mode 0 frame; the clock stands low between frames
    task automatic xfer(input logic [31:0] d, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        oe_seen = 1'b0;
        tick(1);
        cs_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            si = d[31-i];
            tick(4);
            sck = 1'b1;
            tick(4);
            rx = {rx[14:0], so_line};
            oe_seen = oe_seen | ~so_oe_n;
            sck = 1'b0;
        end
        tick(4);
        cs_n = 1'b1;
        si = ~si;
        tick(10);
    endtask
endmodule

// ---- dv/fscc_top_tb_top.sv ----
module fscc_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {
        logic        wren;
        logic        fz;
        logic        wp_n;
        logic [31:0] d;
        int          n;
        logic [5:0]  exp;
    } fscc_row_t;

    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic cs_n, sck, si, so_out, so_oe_n;
    logic wp_n_in, wp_n_out, wp_n_oe_n, hold_n_in, hold_n_out, hold_n_oe_n;
    logic busy_in = 1'b0;
    logic prog_paused_in = 1'b0;
    logic erase_paused_in = 1'b0;
    logic lockdown_frozen = 1'b0;
    logic nv_quad_io_enable = 1'b0;
    logic wp_drv = 1'b1;
    logic hold_drv = 1'b1;
    logic busy_flag, program_paused_flag, erase_paused_flag, write_latch_flag;
    logic protection_lock_bit, soft_reset_allow, lockdown_allow;
    logic global_protect, global_unprotect, nv_quad_wr, nv_quad_wdata;
    logic quad_cmd_accept, bad_cmd, wd;
    logic [15:0] rx;
    int errors = 0;
    int comparisons = 0;
    int n_gp = 0, n_gu = 0, n_wr = 0, n_acc = 0, n_bad = 0, c0, c1;
    fscc_row_t rows[15];

    always #25 clk_sys = ~clk_sys;

    // Pins the design leaves released take the testbench levels wp_drv and hold_drv
    assign wp_n_in = (wp_n_oe_n === 1'b0) ? wp_n_out : wp_drv;
    assign hold_n_in = (hold_n_oe_n === 1'b0) ? hold_n_out : hold_drv;

    fscc_top fscc_top_inst (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .sck(sck), .si(si),
        .so_out(so_out), .so_oe_n(so_oe_n), .wp_n_in(wp_n_in), .wp_n_out(wp_n_out),
        .wp_n_oe_n(wp_n_oe_n), .hold_n_in(hold_n_in), .hold_n_out(hold_n_out),
        .hold_n_oe_n(hold_n_oe_n), .busy_in(busy_in), .prog_paused_in(prog_paused_in),
        .erase_paused_in(erase_paused_in), .lockdown_frozen(lockdown_frozen),
        .nv_quad_io_enable(nv_quad_io_enable), .busy_flag(busy_flag),
        .program_paused_flag(program_paused_flag), .erase_paused_flag(erase_paused_flag),
        .write_latch_flag(write_latch_flag), .protection_lock_bit(protection_lock_bit),
        .soft_reset_allow(soft_reset_allow), .lockdown_allow(lockdown_allow),
        .global_protect(global_protect), .global_unprotect(global_unprotect),
        .nv_quad_wr(nv_quad_wr), .nv_quad_wdata(nv_quad_wdata),
        .quad_cmd_accept(quad_cmd_accept), .bad_cmd(bad_cmd));

    fscc_host_model fscc_host_model_inst (.clk_sys(clk_sys), .cs_n(cs_n), .sck(sck),
        .si(si), .so_out(so_out), .so_oe_n(so_oe_n));

    ////////////////////////////////////////////////////////////////////////////////
    // Pulse counters, so a pulse is never missed between frames
    always @(posedge clk_sys)
    begin
        if (global_protect === 1'b1) n_gp++;
        if (global_unprotect === 1'b1) n_gu++;
        if (quad_cmd_accept === 1'b1) n_acc++;
        if (bad_cmd === 1'b1) n_bad++;
        if (nv_quad_wr === 1'b1)
        begin
            n_wr++;
            wd = nv_quad_wdata;
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        if (errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic cmd(input logic [31:0] d, input int n);
        fscc_host_model_inst.xfer(d, n, rx);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #2000000;
        errors++;
        close_out();
    end

    initial
    begin
        // exp: latch, lock, reset allow, lockdown allow, protect pulse, unprotect pulse
        rows = '{
            '{1'b0, 1'b0, 1'b1, 32'h06000000, 8, 6'b100000},
            '{1'b0, 1'b0, 1'b1, 32'h10000000, 4, 6'b100000},
            '{1'b0, 1'b0, 1'b1, 32'h01000000, 8, 6'b000000},
            '{1'b1, 1'b0, 1'b1, 32'h01BC0000, 16, 6'b010010},
            '{1'b0, 1'b0, 1'b1, 32'h01000000, 16, 6'b010000},
            '{1'b1, 1'b0, 1'b0, 32'h01000000, 16, 6'b010000},
            '{1'b1, 1'b0, 1'b1, 32'h013C0000, 16, 6'b000000},
            '{1'b1, 1'b0, 1'b1, 32'h01000000, 16, 6'b000001},
            '{1'b1, 1'b0, 1'b1, 32'h01800000, 12, 6'b000000},
            '{1'b1, 1'b0, 1'b0, 32'h01BC0000, 24, 6'b010010},
            '{1'b1, 1'b0, 1'b1, 32'h31180000, 16, 6'b011100},
            '{1'b1, 1'b0, 1'b1, 32'h31080000, 16, 6'b010100},
            '{1'b1, 1'b0, 1'b1, 32'h31100000, 20, 6'b010100},
            '{1'b1, 1'b0, 1'b1, 32'h31100000, 8, 6'b010100},
            '{1'b1, 1'b1, 1'b1, 32'h31180000, 24, 6'b011000}};
        fscc_host_model_inst.tick(20);
        rstn = 1'b1;
        fscc_host_model_inst.tick(2);
        check("reset", {write_latch_flag, protection_lock_bit, soft_reset_allow,
            lockdown_allow, so_oe_n, wp_n_oe_n, hold_n_oe_n}, 7'b0000111);
        for (int i = 0; i < 8; i++)
        begin
            {busy_in, prog_paused_in, erase_paused_in} = i[2:0];
            fscc_host_model_inst.tick(3);
            check("flags", {busy_flag, program_paused_flag, erase_paused_flag}, i[2:0]);
        end
        busy_in = 1'b0;
        prog_paused_in = 1'b0;
        erase_paused_in = 1'b0;
        foreach (rows[i])
        begin
            wp_drv = rows[i].wp_n;
            lockdown_frozen = rows[i].fz;
            if (rows[i].wren)
                cmd(32'h06000000, 8);
            c0 = n_gp;
            c1 = n_gu;
            cmd(rows[i].d, rows[i].n);
            check("status", {write_latch_flag, protection_lock_bit, soft_reset_allow,
                lockdown_allow, 1'(n_gp - c0), 1'(n_gu - c1)}, rows[i].exp);
        end
        wp_drv = 1'b1;
        lockdown_frozen = 1'b0;
        // Hand-written cases: configuration read, quad opcodes, configuration write
        for (int q = 0; q < 2; q++)
        begin
            nv_quad_io_enable = q[0];
            cmd(32'h3F000000, 24);
            check("config", rx, {q[0], 7'h00, q[0], 7'h00});
            check("so float", so_oe_n, 1'b1);
            c0 = n_acc;
            c1 = n_bad;
            cmd(32'h32000000, 8);
            cmd(32'h6B000000, 8);
            check("quad", {8'(n_acc - c0), 8'(n_bad - c1)}, q ? 16'h0200 : 16'h0002);
            check("pin oe", {wp_n_oe_n, hold_n_oe_n}, 2'b11);
        end
        cmd(32'h3F000000, 11);
        check("so float", so_oe_n, 1'b1);
        busy_in = 1'b1;
        fscc_host_model_inst.tick(3);
        cmd(32'h3F000000, 24);
        check("busy read", fscc_host_model_inst.oe_seen, 1'b0);
        busy_in = 1'b0;
        c0 = 0;
        while (busy_flag === 1'b1 && c0 < 8)
        begin
            fscc_host_model_inst.tick(1);
            c0++;
        end
        check("busy poll", 16'(c0), 16'h0001);
        c0 = n_wr;
        cmd(32'h06000000, 8);
        cmd(32'h3E800000, 16);
        check("config write", {1'(n_wr - c0), wd, write_latch_flag}, 3'b110);
        // Hold and write-protect act only while the quad bit is 0
        hold_drv = 1'b0;
        wp_drv = 1'b0;
        for (int q = 0; q < 2; q++)
        begin
            nv_quad_io_enable = q[0];
            cmd(32'h06000000, 8);
            check("hold", write_latch_flag, q[0]);
        end
        cmd(32'h01000000, 16);
        check("wp quad", protection_lock_bit, 1'b0);
        hold_drv = 1'b1;
        wp_drv = 1'b1;
        rstn = 1'b0;
        fscc_host_model_inst.tick(3);
        rstn = 1'b1;
        fscc_host_model_inst.tick(1);
        check("rereset", {write_latch_flag, protection_lock_bit, soft_reset_allow}, 3'b000);
        close_out();
    end
endmodule
